/* bench/mem_model.sv */
// Data memory model beside the skip unit
`timescale 1ns/1ns
module mem_model (
    input  wire logic                    clk_sys, req_valid,
    input  wire skip_ops_pkg::skip_req_s req,
    input  wire skip_ops_pkg::mem_wr_s   mem_wr_ff,
    output logic [7:0]                   mem_rdata
);
logic [7:0] mem [256];
// Operand only valid while selected
assign mem_rdata = req_valid ? mem[req.addr] : ~mem[req.addr];
always @(posedge clk_sys)
    if (mem_wr_ff.we) mem[mem_wr_ff.addr] <= mem_wr_ff.data;
endmodule : mem_model

/* bench/skip_ops_asserts.sv */
// Checker for the skip execution unit
`timescale 1ns/1ns
module skip_ops_asserts (
    input wire logic                    clk_sys, resetn, req_valid,
    input wire skip_ops_pkg::skip_req_s req,
    input wire logic [7:0]              mem_rdata, acc_ff,
    input wire skip_ops_pkg::mem_wr_s   mem_wr_ff,
    input wire logic                    acc_we_ff, done_ff, skip_ff,
    input wire logic                    dummy_ff, busy_ff, flag_we_ff
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!resetn);
wire tk  = req_valid && !busy_ff;
wire t1  = tk && req.op == skip_ops_pkg::OP_INC_MEM_SKIP_ZERO;
wire t2  = tk && req.op == skip_ops_pkg::OP_INC_TO_WORK_SKIP_ZERO;
wire t3  = tk && req.op == skip_ops_pkg::OP_SKIP_IF_BIT_SET;
wire hit = mem_rdata[req.bit_sel];
property p_wb; t1 |=> mem_wr_ff.we && mem_wr_ff.data == $past(mem_rdata)
    + 8'h01 && mem_wr_ff.addr == $past(req.addr); endproperty
property p_sz; t1 |=> done_ff && skip_ff == ($past(mem_rdata) == 8'hFF);
    endproperty
property p_dm; skip_ff |-> dummy_ff ##1 !dummy_ff && !done_ff; endproperty
property p_rf; busy_ff && req_valid |=> !done_ff; endproperty
property p_ac; t2 |=> acc_we_ff && !mem_wr_ff.we
    && acc_ff == $past(mem_rdata) + 8'h01; endproperty
property p_as; t2 |=> done_ff && skip_ff == (acc_ff == 8'h00); endproperty
property p_bt; t3 |=> done_ff && skip_ff == $past(hit) && !mem_wr_ff.we;
    endproperty
property p_fl; flag_we_ff == 1'b0; endproperty
a_wb: assert property (p_wb) else $error("write back");
a_sz: assert property (p_sz) else $error("zero skip");
a_dm: assert property (p_dm) else $error("dummy cycle");
a_rf: assert property (p_rf) else $error("busy accept");
a_ac: assert property (p_ac) else $error("acc load");
a_as: assert property (p_as) else $error("acc skip");
a_bt: assert property (p_bt) else $error("bit skip");
a_fl: assert property (p_fl) else $error("flag write");
c_sk: cover property (skip_ff && mem_wr_ff.we);
c_ac: cover property (skip_ff && acc_we_ff);
c_ns: cover property (done_ff && !skip_ff);
endmodule : skip_ops_asserts
bind skip_ops skip_ops_asserts u_chk (.*);

/* bench/tb_skip_ops.sv */
// Testbench for the skip execution unit
`timescale 1ns/1ns
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin err_total++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module tb_skip_ops;
logic clk_sys = 0, resetn = 0, req_valid = 0;
skip_ops_pkg::skip_req_s req = '0;
skip_ops_pkg::mem_wr_s mem_wr_ff;
logic [7:0] mem_rdata, acc_ff;
logic acc_we_ff, done_ff, skip_ff, dummy_ff, busy_ff, flag_we_ff;
logic [2:0] got;
int err_total = 0, tests_run = 0, cyc = 0;
always #25 clk_sys = ~clk_sys;
skip_ops DUT (.*);
mem_model MEM (.*);
task run(input logic [1:0] op, input logic [7:0] a, d, input int b, n);
    MEM.mem[a] = d;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{skip_ops_pkg::skip_op_e'(op), a, 3'(b)};
    @(posedge clk_sys);
    if (n == 1) req_valid <= 1'b0;
    #1 got = {done_ff, skip_ff, dummy_ff};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
endtask : run
task t_mem;
    run(2'h1, 8'h10, 8'h05, 0, 1);
    `CHK(got, 3'b100)
    `CHK(MEM.mem[8'h10], 8'h06)
    run(2'h1, 8'h11, 8'hFF, 0, 2);
    `CHK(got, 3'b111)
    `CHK(done_ff, 1'b0)
    `CHK(MEM.mem[8'h11], 8'h00)
endtask : t_mem
task t_acc;
    run(2'h2, 8'h20, 8'h7F, 0, 2);
    `CHK({got, done_ff}, 4'b1001)
    `CHK({acc_ff, MEM.mem[8'h20]}, 16'h807F)
    run(2'h2, 8'h21, 8'hFF, 0, 1);
    `CHK({got, acc_ff}, 11'h700)
endtask : t_acc
task t_bit;
    for (int i = 0; i < 8; i++)
    begin
        run(2'h3, 8'h30, 8'hA5, i, 1);
        `CHK(got, {1'b1, {2{8'hA5 >> i & 8'h01 ? 1'b1 : 1'b0}}})
        `CHK(flag_we_ff, 1'b0)
    end
endtask : t_bit
task tally_and_finish;
    $display("mismatches %0d of %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask : tally_and_finish
always @(posedge clk_sys)
begin
    cyc++;
    if (cyc == 1000)
    begin
        err_total++;
        tally_and_finish();
    end
end
initial
begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_mem();
    t_acc();
    t_bit();
    tally_and_finish();
end
endmodule : tb_skip_ops

/* hw/skip_eval.sv */
// Result and skip-condition evaluation for one operand byte
`timescale 1ns/1ns
module skip_eval #(
    parameter int DATA_W = 8
) (
    // Operation and operand
    input  wire skip_ops_pkg::skip_op_e op,
    input  wire logic [DATA_W-1:0]      operand,
    input  wire logic [2:0]             bit_sel,
    // Results
    output logic [DATA_W-1:0]           result,
    output logic                        skip
);

    always_comb
    begin
        result = operand + {{(DATA_W-1){1'b0}}, 1'b1};
        skip   = 1'b0;
        case (op)
            skip_ops_pkg::OP_INC_MEM_SKIP_ZERO:
                skip = (result == '0);
            skip_ops_pkg::OP_INC_TO_WORK_SKIP_ZERO:
                skip = (result == '0);
            skip_ops_pkg::OP_SKIP_IF_BIT_SET:
                skip = operand[bit_sel];
            default:
                skip = 1'b0;
        endcase
    end

endmodule : skip_eval

/* hw/skip_ops.sv */
// Execution unit for the increment-skip and bit-test-skip instructions
// Function
// - Increment-memory variant adds one and writes it back to the same byte.
// - Incremented memory result zero skips next instruction, else continue.
// - Taken skip substitutes a dummy while next fetches; two cycles total.
// - Accumulator variant loads memory plus one into accumulator only.
// - Accumulator variant skips when new accumulator value is zero.
// - Bit test skips next instruction when selected bit is one.
`timescale 1ns/1ns
module skip_ops #(
    parameter int DATA_W = skip_ops_pkg::DATA_W,
    parameter int ADDR_W = skip_ops_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // Decoder request, operand read data valid in the same cycle
    input  wire logic                    req_valid,
    input  wire skip_ops_pkg::skip_req_s req,
    input  wire logic [DATA_W-1:0]       mem_rdata,
    // Data memory write port
    output skip_ops_pkg::mem_wr_s        mem_wr_ff,
    // Accumulator
    output logic [DATA_W-1:0]            acc_ff,
    output logic                         acc_we_ff,
    // Sequencer control
    output logic                         done_ff,
    output logic                         skip_ff,
    output logic                         dummy_ff,
    output logic                         busy_ff,
    // Status flag write enable, never raised by these operations
    output logic                         flag_we_ff
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DUMMY
    } state_e;

    localparam int CNT_W = 4;

    // Sequencer state
    state_e            state_ff;
    state_e            nxt_state;
    // Dummy cycle counter
    logic [CNT_W-1:0]  dummy_cnt_ff;
    logic [CNT_W-1:0]  nxt_dummy_cnt;
    logic              dummy_last;
    // Evaluated operand
    logic [DATA_W-1:0] result;
    logic              skip_now;
    // Accepted request and its kind
    logic              take;
    logic              take_mem;
    logic              take_acc;

    // Accept only when idle and a real operation is asked
    assign take = req_valid
                  && (state_ff == ST_IDLE)
                  && (req.op != skip_ops_pkg::OP_NONE);

    // Per-operation strobes
    assign take_mem = take
                      && (req.op == skip_ops_pkg::OP_INC_MEM_SKIP_ZERO);
    assign take_acc = take
                      && (req.op == skip_ops_pkg::OP_INC_TO_WORK_SKIP_ZERO);

    // Last dummy cycle reached
    assign dummy_last = (dummy_cnt_ff
                         == CNT_W'(skip_ops_pkg::SKIP_DUMMY_CYC - 1));

    skip_eval #(
        .DATA_W (DATA_W)
    ) u_eval (
        .op      (req.op),
        .operand (mem_rdata),
        .bit_sel (req.bit_sel),
        .result  (result),
        .skip    (skip_now)
    );

    // Sequencing of the dummy cycle
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (take && skip_now)
                    nxt_state = ST_DUMMY;
            ST_DUMMY:
            begin
                if (dummy_last)
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Dummy cycle count, cleared while idle
    always_comb
    begin
        nxt_dummy_cnt = dummy_cnt_ff;
        if (state_ff == ST_IDLE)
        begin
            nxt_dummy_cnt = '0;
        end
        else if (!dummy_last)
        begin
            nxt_dummy_cnt = dummy_cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            dummy_cnt_ff <= '0;
        else
            dummy_cnt_ff <= nxt_dummy_cnt;
    end

    // Memory write-back, strobe only for the write-back variant
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_wr_ff <= '0;
        end
        else
        begin
            mem_wr_ff.we <= take_mem;
            if (take)
            begin
                mem_wr_ff.addr <= req.addr;
                mem_wr_ff.data <= result;
            end
        end
    end

    // Accumulator write strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            acc_we_ff <= 1'b0;
        else
            acc_we_ff <= take_acc;
    end

    // Accumulator, memory left alone for this variant
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_ff <= skip_ops_pkg::ACC_RST;
        end
        else if (take_acc)
        begin
            acc_ff <= result;
        end
    end

    // Completion pulse
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            done_ff <= 1'b0;
        else
            done_ff <= take;
    end

    // Skip pulse with completion
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            skip_ff <= 1'b0;
        else
            skip_ff <= take && skip_now;
    end

    // Dummy instruction indication
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            dummy_ff <= 1'b0;
        else
            dummy_ff <= (nxt_state == ST_DUMMY);
    end

    // Requests ignored while busy
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            busy_ff <= 1'b0;
        else
            busy_ff <= (nxt_state == ST_DUMMY);
    end

    // Flags untouched
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            flag_we_ff <= 1'b0;
        else
            flag_we_ff <= 1'b0;
    end

endmodule : skip_ops

/* hw/skip_ops_pkg.sv */
// Package for the increment and bit-skip execution block
package skip_ops_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    // Cycles a taken skip holds the sequencer (dummy cycle count)
    localparam int SKIP_DUMMY_CYC = 1;

    localparam logic [7:0] ACC_RST = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_INC_MEM_SKIP_ZERO,
        OP_INC_TO_WORK_SKIP_ZERO,
        OP_SKIP_IF_BIT_SET
    } skip_op_e;

    // Request from the decoder
    typedef struct packed {
        skip_op_e          op;
        logic [ADDR_W-1:0] addr;
        logic [2:0]        bit_sel;
    } skip_req_s;

    // Write port towards data memory
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_s;

endpackage : skip_ops_pkg
